// >>> core/csc_pkg.sv
// Shared constants and types for the processor sideband and clock control block
package csc_pkg;
  // Register byte offsets on the APB slave
  localparam logic [7:0] SYSCTL_OFF = 8'h00;
  localparam logic [7:0] RSTCTL_OFF = 8'h04;
  localparam logic [7:0] COPERR_OFF = 8'h08;
  localparam logic [7:0] NMICTL_OFF = 8'h0C;
  localparam logic [7:0] PMCTL_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  // System control port fields
  localparam int SYSCTL_WARM_BIT = 0;
  localparam int SYSCTL_GATE_BIT = 1;
  // Reset control fields
  localparam int RSTCTL_SYSRST_BIT = 1;
  localparam int RSTCTL_RCPU_BIT = 2;
  // NMI control fields (write) and pending flags (read)
  localparam int NMI_SERR_DIS_BIT = 0;
  localparam int NMI_IOCHK_DIS_BIT = 1;
  localparam int NMI_MASK_BIT = 2;
  localparam int NMI_SERR_PEND_BIT = 4;
  localparam int NMI_IOCHK_PEND_BIT = 5;
  // Power management control fields
  localparam int PM_SMI_SW_BIT = 0;
  localparam int PM_STP_SW_BIT = 1;
  localparam int PM_FPU_ERROR_IN_EN_BIT = 2;
  localparam int PM_POS_BIT = 3;
  localparam int PM_DEEP_BIT = 4;
  localparam int PM_SMI_HW_EN_BIT = 5;
  localparam int PM_STP_HW_EN_BIT = 6;
  localparam int PM_WIDTH = 7;
  // Reset values
  localparam logic [2:0] NMICTL_RST = 3'h0;
  localparam logic [PM_WIDTH-1:0] PMCTL_RST = 7'h00;
  // Timing
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint RST_HOLD_NS = 2_000_000;
  localparam int RST_HOLD_CYC = int'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int WARM_CYC = 64;
  localparam int ISA_DIV = 4;

  // NMI control register contents
  typedef struct packed {
    logic mask;
    logic iochk_dis;
    logic serr_dis;
  } csc_nmi_s;
endpackage : csc_pkg

// >>> core/csc_hold_timer.sv
// Retriggerable hold timer: busy for LEN cycles after each start
`timescale 1ns/1ps
`default_nettype none
module csc_hold_timer #(
  parameter int LEN = 64,
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy
);
  logic [W-1:0] cnt_q;

  // Load on start, count down while busy
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= W'(LEN - 1);
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (cnt_q == '0)
        busy <= 1'b0;
      else
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : csc_hold_timer
`default_nettype wire

// >>> core/csc_sideband.sv
// Processor sideband and clock control block with APB registers
// Functional notes
// - Address-20 mask comes from the quick gate bit and the gate pin.
// - Processor reset held at power-up until 2 ms after power good.
// - Software hard reset holds processor reset at least 2 ms.
// - Processor reset releases on a rising host-bus clock edge.
// - Warm restart polarity follows the processor-type strap.
// - Enabled FPU error raises an internal interrupt request.
// - Coprocessor error write during FPU error sets ignore until error negates.
// - Coprocessor error write without FPU error leaves ignore negated.
// - Reset-processor bit rising with system-reset bit 0 starts warm restart.
// - Shutdown cycle, keyboard reset or port bit 0 write start warm restart.
// - Warm restart stays active 64 clocks then negates.
// - Error or I/O-check input raises NMI subject to source enables.
// - NMI delivered only with both disable bits and mask bit zero.
// - Setting a source disable bit clears its pending NMI.
// - NMI output driven low on host bus reset.
// - System-management interrupt is active low, synchronous, on enabled events.
// - Clock-stop request is active low and synchronous to the clock.
// - Expansion bus clock is the host-bus clock divided by four.
// - Expansion bus clock may be stretched low to align with latch enable.
// - Expansion bus clock runs through processor reset, held low in host-bus reset and power-on suspend.
// - Keep-alive clock output stops in suspend-to-disk and soft-off.
`timescale 1ns/1ps
`default_nettype none
module csc_sideband #(
  parameter int RST_HOLD = csc_pkg::RST_HOLD_CYC,
  parameter int WARM_LEN = csc_pkg::WARM_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_good,
  input wire logic gate_input_pin,
  input wire logic fpu_error_in_n,
  input wire logic keyboard_reset_request_n,
  input wire logic processor_type_strap,
  input wire logic system_error_in_n,
  input wire logic io_check_in,
  input wire logic smi_hw_event,
  input wire logic stp_hw_event,
  input wire logic shutdown_cycle,
  input wire logic isa_stretch_req,
  input wire logic rtc_clk_in,
  output logic address_bit20_mask_n,
  output logic processor_reset_out,
  output logic warm_restart_out,
  output logic ignore_fpu_error_out_n,
  output logic fpu_irq_req,
  output logic nmi_out,
  output logic system_mgmt_interrupt_n,
  output logic clock_stop_request_n,
  output logic expansion_bus_clock,
  output logic suspend_keepalive_clock
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] pg_q, gate_q, fpu_error_in_q, kbd_q, strap_q, serr_q, iochk_q, rtc_q;
  logic pg_s, gate_s, fpu_error_in_s, kbd_s, serr_s, iochk_s, rtc_s;
  logic pg_d1_q, kbd_d1_q;
  logic quick_gate_q, sysrst_q, rcpu_q, ptype_q, ignore_q;
  logic serr_pend_q, iochk_pend_q;
  csc_pkg::csc_nmi_s nmi_ctl_q;
  logic [csc_pkg::PM_WIDTH-1:0] pm_q;
  logic [1:0] div_q;
  logic wr_en, rd_en, hit;
  logic hard_start, warm_start, hard_busy, warm_busy;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Two-stage synchronisers for pins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_q <= 2'h0;
      gate_q <= 2'h0;
      fpu_error_in_q <= 2'h3;
      kbd_q <= 2'h3;
      strap_q <= 2'h0;
      serr_q <= 2'h3;
      iochk_q <= 2'h0;
      rtc_q <= 2'h0;
    end
    else
    begin
      pg_q <= {pg_q[0], power_good};
      gate_q <= {gate_q[0], gate_input_pin};
      fpu_error_in_q <= {fpu_error_in_q[0], fpu_error_in_n};
      kbd_q <= {kbd_q[0], keyboard_reset_request_n};
      strap_q <= {strap_q[0], processor_type_strap};
      serr_q <= {serr_q[0], system_error_in_n};
      iochk_q <= {iochk_q[0], io_check_in};
      rtc_q <= {rtc_q[0], rtc_clk_in};
    end
  end
  assign pg_s = pg_q[1];
  assign gate_s = gate_q[1];
  assign fpu_error_in_s = ~fpu_error_in_q[1];
  assign kbd_s = ~kbd_q[1];
  assign serr_s = ~serr_q[1];
  assign iochk_s = iochk_q[1];
  assign rtc_s = rtc_q[1];

  // Edge history for power good and keyboard reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_d1_q <= 1'b0;
      kbd_d1_q <= 1'b0;
    end
    else
    begin
      pg_d1_q <= pg_s;
      kbd_d1_q <= kbd_s;
    end
  end

  // APB decode: zero wait states, answer in the access cycle
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  always_comb
  begin
    hit = 1'b1;
    case (paddr)
      csc_pkg::SYSCTL_OFF, csc_pkg::RSTCTL_OFF, csc_pkg::COPERR_OFF,
      csc_pkg::NMICTL_OFF, csc_pkg::PMCTL_OFF, csc_pkg::STATUS_OFF: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
        pslverr <= !hit;
      if (rd_en)
      begin
        prdata <= 32'h0000_0000;
        case (paddr)
          csc_pkg::SYSCTL_OFF: prdata[csc_pkg::SYSCTL_GATE_BIT] <= quick_gate_q;
          csc_pkg::RSTCTL_OFF:
          begin
            prdata[csc_pkg::RSTCTL_SYSRST_BIT] <= sysrst_q;
            prdata[csc_pkg::RSTCTL_RCPU_BIT] <= rcpu_q;
          end
          csc_pkg::NMICTL_OFF:
          begin
            prdata[2:0] <= nmi_ctl_q;
            prdata[csc_pkg::NMI_SERR_PEND_BIT] <= serr_pend_q;
            prdata[csc_pkg::NMI_IOCHK_PEND_BIT] <= iochk_pend_q;
          end
          csc_pkg::PMCTL_OFF: prdata[csc_pkg::PM_WIDTH-1:0] <= pm_q;
          csc_pkg::STATUS_OFF: prdata[7:0] <= {ptype_q, ignore_q, fpu_error_in_s, warm_busy,
                                               processor_reset_out, gate_s, pg_s, nmi_out};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software-writable control registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quick_gate_q <= 1'b0;
      sysrst_q <= 1'b0;
      rcpu_q <= 1'b0;
      nmi_ctl_q <= csc_pkg::NMICTL_RST;
      pm_q <= csc_pkg::PMCTL_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        csc_pkg::SYSCTL_OFF: quick_gate_q <= pwdata[csc_pkg::SYSCTL_GATE_BIT];
        csc_pkg::RSTCTL_OFF:
        begin
          sysrst_q <= pwdata[csc_pkg::RSTCTL_SYSRST_BIT];
          rcpu_q <= pwdata[csc_pkg::RSTCTL_RCPU_BIT];
        end
        csc_pkg::NMICTL_OFF: nmi_ctl_q <= pwdata[2:0];
        csc_pkg::PMCTL_OFF: pm_q <= pwdata[csc_pkg::PM_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  assign warm_start = (wr_en && paddr == csc_pkg::RSTCTL_OFF && !pwdata[csc_pkg::RSTCTL_SYSRST_BIT]
                       && pwdata[csc_pkg::RSTCTL_RCPU_BIT] && !rcpu_q)
                      || shutdown_cycle || (kbd_s && !kbd_d1_q)
                      || (wr_en && paddr == csc_pkg::SYSCTL_OFF && pwdata[csc_pkg::SYSCTL_WARM_BIT]);
  assign hard_start = (wr_en && paddr == csc_pkg::RSTCTL_OFF && pwdata[csc_pkg::RSTCTL_SYSRST_BIT]
                       && pwdata[csc_pkg::RSTCTL_RCPU_BIT] && !rcpu_q) || (pg_s && !pg_d1_q);

  csc_hold_timer #(.LEN(RST_HOLD), .W(32)) u_hard_timer (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(hard_start),
    .busy(hard_busy)
  );

  csc_hold_timer #(.LEN(WARM_LEN), .W(8)) u_warm_timer (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(warm_start),
    .busy(warm_busy)
  );

  // Processor reset and strap capture
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      processor_reset_out <= 1'b1;
      ptype_q <= 1'b0;
    end
    else
    begin
      processor_reset_out <= !pg_s || hard_start || hard_busy;
      if (processor_reset_out)
        ptype_q <= strap_q[1]; // Strap is stable while the processor is held
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      warm_restart_out <= 1'b0;
    else
      warm_restart_out <= warm_busy ^ ptype_q;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      address_bit20_mask_n <= 1'b0;
    else
      address_bit20_mask_n <= quick_gate_q || gate_s;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ignore_q <= 1'b0;
      fpu_irq_req <= 1'b0;
    end
    else
    begin
      fpu_irq_req <= fpu_error_in_s && pm_q[csc_pkg::PM_FPU_ERROR_IN_EN_BIT];
      if (wr_en && paddr == csc_pkg::COPERR_OFF && fpu_error_in_s)
        ignore_q <= 1'b1;
      else if (!fpu_error_in_s)
        ignore_q <= 1'b0;
    end
  end
  // Active-low ignore pin straight from its own flip-flop
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ignore_fpu_error_out_n <= 1'b1;
    else
      ignore_fpu_error_out_n <= !ignore_q;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serr_pend_q <= 1'b0;
      iochk_pend_q <= 1'b0;
    end
    else
    begin
      if (serr_s && !nmi_ctl_q.serr_dis)
        serr_pend_q <= 1'b1;
      else if (nmi_ctl_q.serr_dis)
        serr_pend_q <= 1'b0;
      if (iochk_s && !nmi_ctl_q.iochk_dis)
        iochk_pend_q <= 1'b1;
      else if (nmi_ctl_q.iochk_dis)
        iochk_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      nmi_out <= 1'b0;
    else
      nmi_out <= (serr_pend_q || iochk_pend_q) && !nmi_ctl_q.mask
                 && !nmi_ctl_q.serr_dis && !nmi_ctl_q.iochk_dis;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      system_mgmt_interrupt_n <= 1'b1;
      clock_stop_request_n <= 1'b1;
    end
    else
    begin
      system_mgmt_interrupt_n <= !(pm_q[csc_pkg::PM_SMI_SW_BIT]
                                   || (smi_hw_event && pm_q[csc_pkg::PM_SMI_HW_EN_BIT]));
      clock_stop_request_n <= !(pm_q[csc_pkg::PM_STP_SW_BIT]
                                || (stp_hw_event && pm_q[csc_pkg::PM_STP_HW_EN_BIT]));
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      div_q <= 2'h0;
    else if (pm_q[csc_pkg::PM_POS_BIT])
      div_q <= 2'h0;
    else if (!(div_q == 2'h1 && isa_stretch_req))
      div_q <= div_q + 2'h1;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      expansion_bus_clock <= 1'b0;
    else
      expansion_bus_clock <= div_q[1] && !pm_q[csc_pkg::PM_POS_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      suspend_keepalive_clock <= 1'b0;
    else
      suspend_keepalive_clock <= rtc_s && !pm_q[csc_pkg::PM_DEEP_BIT];
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  int unsigned warm_run_q;
  int unsigned rst_run_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      warm_run_q <= 0;
      rst_run_q <= 0;
    end
    else
    begin
      warm_run_q <= warm_busy ? warm_run_q + 1 : 0;
      rst_run_q <= processor_reset_out ? rst_run_q + 1 : 0;
    end
  end

  sequence coperr_wr_s;
    wr_en && paddr == csc_pkg::COPERR_OFF;
  endsequence

  mask_comb_a: assert property (address_bit20_mask_n == $past(quick_gate_q || gate_s))
    else $error("address mask does not follow gate inputs");
  reset_hold_a: assert property ($fell(processor_reset_out) && $past(hard_busy, 2)
    |-> $past(rst_run_q) >= RST_HOLD)
    else $error("processor reset released early");
  warm_len_a: assert property ($fell(warm_busy) |-> warm_run_q == WARM_LEN)
    else $error("warm restart length wrong");
  warm_pol_a: assert property (warm_restart_out == ($past(warm_busy) ^ $past(ptype_q)))
    else $error("warm restart polarity wrong");
  ignore_set_a: assert property (coperr_wr_s ##0 fpu_error_in_s |=> ignore_q)
    else $error("ignore not set on coprocessor write");
  ignore_off_a: assert property (!fpu_error_in_s |=> !ignore_q)
    else $error("ignore asserted without FPU error");
  nmi_gate_a: assert property (nmi_out |-> $past(!nmi_ctl_q.mask && !nmi_ctl_q.serr_dis
    && !nmi_ctl_q.iochk_dis))
    else $error("NMI delivered while gated");
  nmi_clear_a: assert property (nmi_ctl_q.serr_dis |=> !serr_pend_q)
    else $error("pending error not cleared by disable");
  isa_high_a: assert property ($rose(div_q[1]) ##1 !pm_q[csc_pkg::PM_POS_BIT]
    |-> div_q[1] ##1 !div_q[1])
    else $error("expansion clock high phase wrong");
  smi_sync_a: assert property ($past(pm_q[csc_pkg::PM_SMI_SW_BIT]) |-> !system_mgmt_interrupt_n)
    else $error("management interrupt not asserted");
  keep_stop_a: assert property (pm_q[csc_pkg::PM_DEEP_BIT] |=> !suspend_keepalive_clock)
    else $error("keep-alive clock runs in deep suspend");
endmodule : csc_sideband
`default_nettype wire

// >>> verification/csc_cpu_model.sv
// Behavioural model of the host processor pins and the real-time clock source
`timescale 1ns/1ps
`default_nettype none
module csc_cpu_model (
  input wire logic clk,
  input wire logic strap,
  input wire logic warm,
  input wire logic fault,
  output logic fpu_error_n,
  output logic rtc_clk,
  output int warm_len,
  output int warm_seen
);
  int run = 0;
  // error pin: a coprocessor fault drives the active-low error pin
  assign fpu_error_n = ~fault;
  // Free-running 32.768 kHz reference, half period rounded to 1 ns
  initial
  begin
    rtc_clk = 1'h0;
    warm_len = 0;
    warm_seen = 0;
    forever #15259 rtc_clk = ~rtc_clk;
  end
  // restart width: strap picks the active level, count each pulse
  always @(posedge clk)
  begin
    if (strap ? ~warm : warm)
      run <= run + 1;
    else if (run != 0)
    begin
      warm_len <= run;
      warm_seen <= warm_seen + 1;
      run <= 0;
    end
  end
endmodule : csc_cpu_model
`default_nettype wire

// >>> verification/tb_csc_sideband.sv
// Self-checking bench for the processor sideband and clock control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_csc_sideband;
  localparam int RST_HOLD = 20;
  localparam int WARM_LEN = 64;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic power_good = 1'h0, gate_pin = 1'h0, kbd_n = 1'h1, strap = 1'h0, serr_n = 1'h1;
  logic iochk = 1'h0, smi_hw = 1'h0, stp_hw = 1'h0, shutdown = 1'h0, stretch = 1'h0;
  logic fault = 1'h0;
  logic fpu_n, rtc, mask_n, cpu_rst, warm, ign_n, irq, nmi, smi_n, stp_n, ebc, ska;
  int warm_len, warm_seen, r;
  int err_count = 0;
  int tests_run = 0;
  // Mode table: pm value, smi event, stop event, expected smi_n, expected stop_n
  logic [11:0] tbl [5] = '{12'h011, 12'h022, 12'h209, 12'h00F, 12'h406};

  csc_sideband #(.RST_HOLD(RST_HOLD), .WARM_LEN(WARM_LEN)) dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .power_good(power_good),
    .gate_input_pin(gate_pin),
    .fpu_error_in_n(fpu_n),
    .keyboard_reset_request_n(kbd_n),
    .processor_type_strap(strap),
    .system_error_in_n(serr_n),
    .io_check_in(iochk),
    .smi_hw_event(smi_hw),
    .stp_hw_event(stp_hw),
    .shutdown_cycle(shutdown),
    .isa_stretch_req(stretch),
    .rtc_clk_in(rtc),
    .address_bit20_mask_n(mask_n),
    .processor_reset_out(cpu_rst),
    .warm_restart_out(warm),
    .ignore_fpu_error_out_n(ign_n),
    .fpu_irq_req(irq),
    .nmi_out(nmi),
    .system_mgmt_interrupt_n(smi_n),
    .clock_stop_request_n(stp_n),
    .expansion_bus_clock(ebc),
    .suspend_keepalive_clock(ska)
  );

  csc_cpu_model cpu (
    .clk(core_clk),
    .strap(strap),
    .warm(warm),
    .fault(fault),
    .fpu_error_n(fpu_n),
    .rtc_clk(rtc),
    .warm_len(warm_len),
    .warm_seen(warm_seen)
  );

  // bus clock: host-bus clock never stops
  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  // One APB transfer, held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1 && t < 20)
    begin
      @(posedge core_clk);
      t++;
    end
    if (t == 20)
      err_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask : apb

  // Waits for the model to report a finished restart pulse
  task automatic warm_chk();
    int s;
    int t;
    s = warm_seen;
    t = 0;
    while (warm_seen == s && t < 300)
    begin
      @(posedge core_clk);
      t++;
    end
    `CHK("warm seen", s + 1, warm_seen)
    `CHK("warm width", WARM_LEN, warm_len)
  endtask : warm_chk

  // Counts rising edges of the expansion or keep-alive clock over k cycles
  task automatic rises(input int k, input logic sel, output int c);
    logic p;
    c = 0;
    p = sel ? ska : ebc;
    repeat (k)
    begin
      @(posedge core_clk);
      if ((sel ? ska : ebc) === 1'h1 && p === 1'h0)
        c++;
      p = sel ? ska : ebc;
    end
  endtask : rises

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    cyc(20);
    `CHK("nmi in reset", 1'h0, nmi)
    rstn <= 1'h1;
    cyc(40);
    `CHK("reset without power", 1'h1, cpu_rst)
    power_good <= 1'h1;
    cyc(RST_HOLD);
    `CHK("reset hold", 1'h1, cpu_rst)
    cyc(10);
    `CHK("reset release", 1'h0, cpu_rst)
    `CHK("warm idle low", 1'h0, warm)
    apb(1'h0, csc_pkg::NMICTL_OFF, 32'h0000_0000);
    `CHK("nmi ctl reset", 32'h0000_0000, rdat)
    `CHK("pready", 1'h1, pready)
    apb(1'h0, 8'h20, 32'h0000_0000);
    `CHK("unmapped err", 1'h1, rerr)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    $display("power-up test done");
    strap <= 1'h1;
    apb(1'h1, csc_pkg::RSTCTL_OFF, 32'h0000_0002);
    apb(1'h1, csc_pkg::RSTCTL_OFF, 32'h0000_0006);
    cyc(RST_HOLD - 2);
    `CHK("hard reset hold", 1'h1, cpu_rst)
    cyc(10);
    `CHK("hard reset end", 1'h0, cpu_rst)
    `CHK("warm idle high", 1'h1, warm)
    $display("hard reset test done");
    apb(1'h1, csc_pkg::SYSCTL_OFF, 32'h0000_0001);
    warm_chk();
    kbd_n <= 1'h0;
    cyc(4);
    kbd_n <= 1'h1;
    warm_chk();
    shutdown <= 1'h1;
    cyc(1);
    shutdown <= 1'h0;
    warm_chk();
    apb(1'h1, csc_pkg::RSTCTL_OFF, 32'h0000_0000);
    apb(1'h1, csc_pkg::RSTCTL_OFF, 32'h0000_0004);
    warm_chk();
    `CHK("no hard reset", 1'h0, cpu_rst)
    $display("warm restart test done");
    for (int i = 0; i < 4; i++)
    begin
      gate_pin <= i[0];
      apb(1'h1, csc_pkg::SYSCTL_OFF, {30'h0000_0000, i[1], 1'h0});
      cyc(4);
      `CHK("a20 mask", i[1] | i[0], mask_n)
    end
    $display("address mask test done");
    apb(1'h1, csc_pkg::COPERR_OFF, 32'h0000_0000);
    cyc(3);
    `CHK("ignore no error", 1'h1, ign_n)
    apb(1'h1, csc_pkg::PMCTL_OFF, 32'h0000_0004);
    fault <= 1'h1;
    cyc(5);
    `CHK("fpu irq", 1'h1, irq)
    `CHK("ignore before write", 1'h1, ign_n)
    apb(1'h1, csc_pkg::COPERR_OFF, 32'h0000_0000);
    cyc(10);
    `CHK("ignore held", 1'h0, ign_n)
    fault <= 1'h0;
    cyc(5);
    `CHK("ignore cleared", 1'h1, ign_n)
    `CHK("fpu irq off", 1'h0, irq)
    $display("coprocessor test done");
    serr_n <= 1'h0;
    cyc(6);
    `CHK("nmi error", 1'h1, nmi)
    apb(1'h0, csc_pkg::NMICTL_OFF, 32'h0000_0000);
    `CHK("nmi pending", 1'h1, rdat[csc_pkg::NMI_SERR_PEND_BIT])
    apb(1'h1, csc_pkg::NMICTL_OFF, 32'h0000_0001);
    cyc(3);
    `CHK("nmi cleared", 1'h0, nmi)
    serr_n <= 1'h1;
    apb(1'h1, csc_pkg::NMICTL_OFF, 32'h0000_0004);
    iochk <= 1'h1;
    cyc(6);
    `CHK("nmi masked", 1'h0, nmi)
    apb(1'h1, csc_pkg::NMICTL_OFF, 32'h0000_0000);
    cyc(6);
    `CHK("nmi check", 1'h1, nmi)
    apb(1'h1, csc_pkg::NMICTL_OFF, 32'h0000_0002);
    cyc(3);
    `CHK("nmi check cleared", 1'h0, nmi)
    iochk <= 1'h0;
    $display("nmi test done");
    foreach (tbl[i])
    begin
      apb(1'h1, csc_pkg::PMCTL_OFF, {24'h00_0000, tbl[i][11:4]});
      smi_hw <= tbl[i][3];
      stp_hw <= tbl[i][2];
      cyc(4);
      `CHK("smi", tbl[i][1], smi_n)
      `CHK("stop", tbl[i][0], stp_n)
    end
    smi_hw <= 1'h0;
    stp_hw <= 1'h0;
    apb(1'h1, csc_pkg::PMCTL_OFF, 32'h0000_0000);
    $display("power event test done");
    rises(16, 1'h0, r);
    `CHK("expansion rises", 4, r)
    stretch <= 1'h1;
    cyc(2);
    rises(16, 1'h0, r);
    `CHK("stretched", 0, r)
    stretch <= 1'h0;
    apb(1'h1, csc_pkg::PMCTL_OFF, 32'h0000_0008);
    rises(16, 1'h0, r);
    `CHK("suspend clock", 0, r)
    `CHK("suspend level", 1'h0, ebc)
    apb(1'h1, csc_pkg::PMCTL_OFF, 32'h0000_0000);
    rises(700, 1'h1, r);
    `CHK("keepalive runs", 1'h1, r >= 2)
    apb(1'h1, csc_pkg::PMCTL_OFF, 32'h0000_0010);
    cyc(4);
    rises(700, 1'h1, r);
    `CHK("keepalive stops", 0, r)
    $display("clock test done");
    summarize();
  end

  // Cuts a hang short well beyond the expected run length
  initial
  begin
    cyc(20000);
    err_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule : tb_csc_sideband
`default_nettype wire
